/* File: rtl/rpmd_top.sv */
// Root-port received-message decoder with turn-off request
`timescale 1ns/1ps
module rpmd_top (
	input  wire logic                          core_clk_i,
	input  wire logic                          rst_i,
	// Message receive side
	input  wire logic                          rx_msg_valid_i,
	input  wire logic [rpmd_pkg::CODE_W-1:0]   rx_msg_code_i,
	input  wire logic [rpmd_pkg::RID_W-1:0]    rx_msg_rid_i,
	// Link state from the link machine
	input  wire logic [rpmd_pkg::LS_W-1:0]     link_state_i,
	// Turn-off transmit handshake
	input  wire logic                          turnoff_request_n_i,
	output logic                               tx_turnoff_valid_o,
	input  wire logic                          tx_turnoff_ready_i,
	output logic                               turnoff_busy_o,
	output logic                               turnoff_l3_done_o,
	// User side
	output logic                               msg_strobe_o,
	output logic [rpmd_pkg::RID_W-1:0]         msg_data_o,
	output logic                               rx_err_cor_flag_o,
	output logic                               rx_err_nonfatal_flag_o,
	output logic                               rx_err_fatal_flag_o,
	output logic                               rx_turnoff_ack_flag_o,
	output logic                               rx_assert_inta_flag_o,
	output logic                               rx_assert_intb_flag_o,
	output logic                               rx_assert_intc_flag_o,
	output logic                               rx_assert_intd_flag_o,
	output logic                               rx_deassert_inta_flag_o,
	output logic                               rx_deassert_intb_flag_o,
	output logic                               rx_deassert_intc_flag_o,
	output logic                               rx_deassert_intd_flag_o,
	output logic [rpmd_pkg::LS_W-1:0]          link_state_o
);

	// ======================================================================
	// State
	typedef struct packed {
		logic                            strobe;
		logic [rpmd_pkg::RID_W-1:0]      rid;
		logic [rpmd_pkg::NUM_FLG-1:0]    flags;
		logic                            de_intd;
		logic [rpmd_pkg::LS_W-1:0]       ls;
	} rpmd_top_s;

	rpmd_top_s                       state_r;
	rpmd_top_s                       state_nxt;
	logic [rpmd_pkg::NUM_FLG-1:0]    code_hit;
	logic                            hit_de_intd;

	// ======================================================================
	// Code match, one comparator per flag
	genvar gi;
	generate
		for (gi = 0; gi < rpmd_pkg::NUM_FLG; gi++) begin : g_match
			assign code_hit[gi] = (rx_msg_code_i ==
				rpmd_pkg::FLG_CODES[gi*rpmd_pkg::CODE_W +: rpmd_pkg::CODE_W]);
		end
	endgenerate

	assign hit_de_intd = (rx_msg_code_i == rpmd_pkg::CODE_DEASSERT_INTD);

	// ======================================================================
	// Next state
	always_comb begin
		state_nxt        = state_r;
		state_nxt.strobe = rx_msg_valid_i;
		state_nxt.ls     = link_state_i;
		if (rx_msg_valid_i) begin
			state_nxt.rid     = rx_msg_rid_i;
			state_nxt.flags   = code_hit;
			state_nxt.de_intd = hit_de_intd;
		end else begin
			state_nxt.flags   = rpmd_pkg::FLG_RST;
			state_nxt.de_intd = 1'b0;
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			state_r.strobe  <= 1'b0;
			state_r.rid     <= rpmd_pkg::RID_RST;
			state_r.flags   <= rpmd_pkg::FLG_RST;
			state_r.de_intd <= 1'b0;
			state_r.ls      <= rpmd_pkg::LS_RST;
		end else begin
			state_r <= state_nxt;
		end
	end

	// ======================================================================
	// Turn-off sequencer
	rpmd_to_if to_if ();

	assign to_if.req_n      = turnoff_request_n_i;
	assign to_if.ack_seen   = state_r.strobe && state_r.flags[rpmd_pkg::FLG_TO_ACK];
	assign to_if.link_state = state_r.ls;
	assign to_if.tx_ready   = tx_turnoff_ready_i;

	rpmd_turnoff u_turnoff (
		.core_clk_i (core_clk_i),
		.rst_i      (rst_i),
		.to_if      (to_if.seq)
	);

	// ======================================================================
	// Outputs
	assign tx_turnoff_valid_o      = to_if.tx_valid;
	assign turnoff_busy_o          = to_if.busy;
	assign turnoff_l3_done_o       = to_if.l3_reached;
	assign msg_strobe_o            = state_r.strobe;
	assign msg_data_o              = state_r.rid;
	assign rx_err_cor_flag_o       = state_r.flags[rpmd_pkg::FLG_ERR_COR];
	assign rx_err_nonfatal_flag_o  = state_r.flags[rpmd_pkg::FLG_ERR_NF];
	assign rx_err_fatal_flag_o     = state_r.flags[rpmd_pkg::FLG_ERR_FATAL];
	assign rx_turnoff_ack_flag_o   = state_r.flags[rpmd_pkg::FLG_TO_ACK];
	assign rx_assert_inta_flag_o   = state_r.flags[rpmd_pkg::FLG_AS_INTA];
	assign rx_assert_intb_flag_o   = state_r.flags[rpmd_pkg::FLG_AS_INTB];
	assign rx_assert_intc_flag_o   = state_r.flags[rpmd_pkg::FLG_AS_INTC];
	assign rx_assert_intd_flag_o   = state_r.flags[rpmd_pkg::FLG_AS_INTD];
	assign rx_deassert_inta_flag_o = state_r.flags[rpmd_pkg::FLG_DE_INTA];
	assign rx_deassert_intb_flag_o = state_r.flags[rpmd_pkg::FLG_DE_INTB];
	assign rx_deassert_intc_flag_o = state_r.flags[rpmd_pkg::FLG_DE_INTC];
	assign rx_deassert_intd_flag_o = state_r.de_intd;
	assign link_state_o            = state_r.ls;

endmodule // rpmd_top

/* File: rtl/rpmd_pkg.sv */
// Constants and types shared by the root-port message decode block
package rpmd_pkg;

	// ======================================================================
	// Widths
	localparam int RID_W   = 16;
	localparam int CODE_W  = 8;
	localparam int LS_W    = 3;
	localparam int NUM_FLG = 11;

	// ======================================================================
	// Message codes of the decoded message types
	localparam logic [CODE_W-1:0] CODE_ERR_COR      = 8'h30;
	localparam logic [CODE_W-1:0] CODE_ERR_NONFATAL = 8'h31;
	localparam logic [CODE_W-1:0] CODE_ERR_FATAL    = 8'h33;
	localparam logic [CODE_W-1:0] CODE_TURNOFF_ACK  = 8'h1B;
	localparam logic [CODE_W-1:0] CODE_ASSERT_INTA  = 8'h20;
	localparam logic [CODE_W-1:0] CODE_ASSERT_INTB  = 8'h21;
	localparam logic [CODE_W-1:0] CODE_ASSERT_INTC  = 8'h22;
	localparam logic [CODE_W-1:0] CODE_ASSERT_INTD  = 8'h23;
	localparam logic [CODE_W-1:0] CODE_DEASSERT_INTA = 8'h24;
	localparam logic [CODE_W-1:0] CODE_DEASSERT_INTB = 8'h25;
	localparam logic [CODE_W-1:0] CODE_DEASSERT_INTC = 8'h26;
	localparam logic [CODE_W-1:0] CODE_DEASSERT_INTD = 8'h27;

	// ======================================================================
	// Flag positions in the flag vector
	localparam int FLG_ERR_COR   = 0;
	localparam int FLG_ERR_NF    = 1;
	localparam int FLG_ERR_FATAL = 2;
	localparam int FLG_TO_ACK    = 3;
	localparam int FLG_AS_INTA   = 4;
	localparam int FLG_AS_INTB   = 5;
	localparam int FLG_AS_INTC   = 6;
	localparam int FLG_AS_INTD   = 7;
	localparam int FLG_DE_INTA   = 8;
	localparam int FLG_DE_INTB   = 9;
	localparam int FLG_DE_INTC   = 10;

	// Code for each flag position, index 0 at the right
	localparam logic [NUM_FLG*CODE_W-1:0] FLG_CODES = {
		CODE_DEASSERT_INTC, CODE_DEASSERT_INTB, CODE_DEASSERT_INTA,
		CODE_ASSERT_INTD, CODE_ASSERT_INTC, CODE_ASSERT_INTB, CODE_ASSERT_INTA,
		CODE_TURNOFF_ACK, CODE_ERR_FATAL, CODE_ERR_NONFATAL, CODE_ERR_COR};

	// ======================================================================
	// Reset values and link state codes
	localparam logic [RID_W-1:0]   RID_RST     = 16'h0000;
	localparam logic [NUM_FLG-1:0] FLG_RST     = 11'h000;
	localparam logic [LS_W-1:0]    LS_RST      = 3'h0;
	localparam logic [LS_W-1:0]    LS_L3_READY = 3'h5;

	// ======================================================================
	// Turn-off sequencer states
	typedef enum logic [2:0] {
		RPMD_TO_IDLE,
		RPMD_TO_SEND,
		RPMD_TO_WAIT_ACK,
		RPMD_TO_WAIT_L3,
		RPMD_TO_DONE
	} rpmd_to_state_e;

endpackage

/* File: rtl/rpmd_to_if.sv */
// Interface between the message decoder and the turn-off sequencer
`timescale 1ns/1ps
interface rpmd_to_if;
	logic                        req_n;
	logic                        ack_seen;
	logic [rpmd_pkg::LS_W-1:0]   link_state;
	logic                        tx_valid;
	logic                        tx_ready;
	logic                        busy;
	logic                        l3_reached;

	modport seq (
		input  req_n,
		input  ack_seen,
		input  link_state,
		input  tx_ready,
		output tx_valid,
		output busy,
		output l3_reached
	);

	modport ctl (
		output req_n,
		output ack_seen,
		output link_state,
		output tx_ready,
		input  tx_valid,
		input  busy,
		input  l3_reached
	);
endinterface

/* File: rtl/rpmd_turnoff.sv */
// Turn-off message sequencer
`timescale 1ns/1ps
module rpmd_turnoff (
	input  wire logic core_clk_i,
	input  wire logic rst_i,
	rpmd_to_if.seq    to_if
);

	typedef struct packed {
		rpmd_pkg::rpmd_to_state_e st;
		logic                     req_n_d;
	} rpmd_to_s;

	rpmd_to_s state_r;
	rpmd_to_s state_nxt;

	// ======================================================================
	// Sequencer
	always_comb begin
		state_nxt         = state_r;
		state_nxt.req_n_d = to_if.req_n;
		case (state_r.st)
			rpmd_pkg::RPMD_TO_IDLE: begin
				if (state_r.req_n_d && !to_if.req_n) begin
					state_nxt.st = rpmd_pkg::RPMD_TO_SEND;
				end
			end
			rpmd_pkg::RPMD_TO_SEND: begin
				if (to_if.tx_ready) begin
					state_nxt.st = rpmd_pkg::RPMD_TO_WAIT_ACK;
				end
			end
			rpmd_pkg::RPMD_TO_WAIT_ACK: begin
				if (to_if.ack_seen) begin
					state_nxt.st = rpmd_pkg::RPMD_TO_WAIT_L3;
				end
			end
			rpmd_pkg::RPMD_TO_WAIT_L3: begin
				if (to_if.link_state == rpmd_pkg::LS_L3_READY) begin
					state_nxt.st = rpmd_pkg::RPMD_TO_DONE;
				end
			end
			rpmd_pkg::RPMD_TO_DONE: begin
				if (to_if.req_n) begin
					state_nxt.st = rpmd_pkg::RPMD_TO_IDLE;
				end
			end
			default: begin
				state_nxt.st = rpmd_pkg::RPMD_TO_IDLE;
			end
		endcase
	end

	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			state_r.st      <= rpmd_pkg::RPMD_TO_IDLE;
			state_r.req_n_d <= 1'b1;
		end else begin
			state_r <= state_nxt;
		end
	end

	assign to_if.tx_valid   = (state_r.st == rpmd_pkg::RPMD_TO_SEND);
	assign to_if.busy       = (state_r.st != rpmd_pkg::RPMD_TO_IDLE);
	assign to_if.l3_reached = (state_r.st == rpmd_pkg::RPMD_TO_DONE);

endmodule // rpmd_turnoff

/* File: bench/rpmd_props.sv */
// Port checker for the message decoder
`timescale 1ns/1ps
module rpmd_props (
	input wire logic	core_clk_i,
	input wire logic	rst_i,
	input wire logic	rx_msg_valid_i,
	input wire logic [rpmd_pkg::CODE_W-1:0]	rx_msg_code_i,
	input wire logic [rpmd_pkg::RID_W-1:0]	rx_msg_rid_i,
	input wire logic [rpmd_pkg::LS_W-1:0]	link_state_i,
	input wire logic	turnoff_request_n_i,
	input wire logic	tx_turnoff_valid_o,
	input wire logic	tx_turnoff_ready_i,
	input wire logic	turnoff_busy_o,
	input wire logic	turnoff_l3_done_o,
	input wire logic	msg_strobe_o,
	input wire logic [rpmd_pkg::RID_W-1:0]	msg_data_o,
	input wire logic	rx_err_cor_flag_o,
	input wire logic	rx_err_nonfatal_flag_o,
	input wire logic	rx_err_fatal_flag_o,
	input wire logic	rx_turnoff_ack_flag_o,
	input wire logic	rx_assert_inta_flag_o,
	input wire logic	rx_assert_intb_flag_o,
	input wire logic	rx_assert_intc_flag_o,
	input wire logic	rx_assert_intd_flag_o,
	input wire logic	rx_deassert_inta_flag_o,
	input wire logic	rx_deassert_intb_flag_o,
	input wire logic	rx_deassert_intc_flag_o,
	input wire logic	rx_deassert_intd_flag_o,
	input wire logic [rpmd_pkg::LS_W-1:0]	link_state_o
);
	wire logic [11:0] flg = {rx_deassert_intd_flag_o, rx_deassert_intc_flag_o,
		rx_deassert_intb_flag_o, rx_deassert_inta_flag_o, rx_assert_intd_flag_o,
		rx_assert_intc_flag_o, rx_assert_intb_flag_o, rx_assert_inta_flag_o,
		rx_turnoff_ack_flag_o, rx_err_fatal_flag_o, rx_err_nonfatal_flag_o, rx_err_cor_flag_o};
	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (rst_i);
	a_strobe_msg: assert property (rx_msg_valid_i |=> msg_strobe_o)
		else $error("strobe missing");
	a_rid_shown: assert property (rx_msg_valid_i |=> msg_data_o == $past(rx_msg_rid_i))
		else $error("wrong requester id");
	a_cor_flag: assert property (rx_msg_valid_i && rx_msg_code_i == rpmd_pkg::CODE_ERR_COR
		|=> rx_err_cor_flag_o) else $error("correctable flag missing");
	a_nf_flag: assert property (rx_msg_valid_i && rx_msg_code_i == rpmd_pkg::CODE_ERR_NONFATAL
		|=> rx_err_nonfatal_flag_o) else $error("non-fatal flag missing");
	a_fatal_flag: assert property (rx_msg_valid_i && rx_msg_code_i == rpmd_pkg::CODE_ERR_FATAL
		|=> rx_err_fatal_flag_o) else $error("fatal flag missing");
	a_ack_flag: assert property (rx_msg_valid_i && rx_msg_code_i == rpmd_pkg::CODE_TURNOFF_ACK
		|=> rx_turnoff_ack_flag_o) else $error("ack flag missing");
	a_flag_onehot: assert property ($onehot0(flg))
		else $error("several flags high");
	a_flag_strobe: assert property (|flg |-> msg_strobe_o)
		else $error("flag without strobe");
	a_tx_answer: assert property ($fell(turnoff_request_n_i) && !turnoff_busy_o
		|-> ##[1:2] tx_turnoff_valid_o) else $error("turn-off not sent");
	a_tx_hold: assert property (tx_turnoff_valid_o && !tx_turnoff_ready_i
		|=> tx_turnoff_valid_o) else $error("turn-off valid dropped");
	a_l3_done: assert property ($rose(turnoff_l3_done_o)
		|-> $past(link_state_o) == rpmd_pkg::LS_L3_READY) else $error("done before L3");
	a_ls_delay: assert property (1'b1 |=> link_state_o == $past(link_state_i))
		else $error("link state not passed on");
endmodule // rpmd_props
bind rpmd_top rpmd_props u_props (
	.core_clk_i              (core_clk_i),
	.rst_i                   (rst_i),
	.rx_msg_valid_i          (rx_msg_valid_i),
	.rx_msg_code_i           (rx_msg_code_i),
	.rx_msg_rid_i            (rx_msg_rid_i),
	.link_state_i            (link_state_i),
	.turnoff_request_n_i     (turnoff_request_n_i),
	.tx_turnoff_valid_o      (tx_turnoff_valid_o),
	.tx_turnoff_ready_i      (tx_turnoff_ready_i),
	.turnoff_busy_o          (turnoff_busy_o),
	.turnoff_l3_done_o       (turnoff_l3_done_o),
	.msg_strobe_o            (msg_strobe_o),
	.msg_data_o              (msg_data_o),
	.rx_err_cor_flag_o       (rx_err_cor_flag_o),
	.rx_err_nonfatal_flag_o  (rx_err_nonfatal_flag_o),
	.rx_err_fatal_flag_o     (rx_err_fatal_flag_o),
	.rx_turnoff_ack_flag_o   (rx_turnoff_ack_flag_o),
	.rx_assert_inta_flag_o   (rx_assert_inta_flag_o),
	.rx_assert_intb_flag_o   (rx_assert_intb_flag_o),
	.rx_assert_intc_flag_o   (rx_assert_intc_flag_o),
	.rx_assert_intd_flag_o   (rx_assert_intd_flag_o),
	.rx_deassert_inta_flag_o (rx_deassert_inta_flag_o),
	.rx_deassert_intb_flag_o (rx_deassert_intb_flag_o),
	.rx_deassert_intc_flag_o (rx_deassert_intc_flag_o),
	.rx_deassert_intd_flag_o (rx_deassert_intd_flag_o),
	.link_state_o            (link_state_o)
);

/* File: bench/rpmd_partner.sv */
// Link-side model: message source and turn-off acceptor
`timescale 1ns/1ps
module rpmd_partner (
	input  wire logic	core_clk_i,
	input  wire logic	tx_valid_i,
	input  wire logic	slow_i,
	output logic	tx_ready_o,
	output logic	msg_valid_o,
	output logic [rpmd_pkg::CODE_W-1:0]	msg_code_o,
	output logic [rpmd_pkg::RID_W-1:0]	msg_rid_o,
	output logic [rpmd_pkg::LS_W-1:0]	link_state_o
);
	initial begin
		tx_ready_o = 1'b0;
		msg_valid_o = 1'b0;
		msg_code_o = 8'h00;
		msg_rid_o = 16'h0000;
		link_state_o = 3'h0;
	end
	// One message; idle lines show the inverse of the last value
	task automatic send(input logic [7:0] c, input logic [15:0] r);
		msg_valid_o = 1'b1;
		msg_code_o = c;
		msg_rid_o = r;
		@(posedge core_clk_i);
		#1;
		msg_valid_o = 1'b0;
		msg_code_o = ~c;
		msg_rid_o = ~r;
	endtask
	always @(posedge core_clk_i) begin
		#1;
		if (tx_valid_i && !tx_ready_o) begin
			repeat (slow_i ? 3 : 0) @(posedge core_clk_i);
			#1 tx_ready_o = 1'b1;
			@(posedge core_clk_i);
			#1 tx_ready_o = 1'b0;
			send(rpmd_pkg::CODE_TURNOFF_ACK, 16'hA5C3);
			link_state_o = rpmd_pkg::LS_L3_READY;
		end
	end
endmodule // rpmd_partner

/* File: bench/testbench.sv */
// Self-checking bench for the message decoder
`timescale 1ns/1ps
module testbench;
	logic core_clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic turnoff_request_n_i = 1'b1;
	logic slow = 1'b1;
	logic rx_msg_valid_i, tx_turnoff_ready_i, msg_strobe_o, tx_turnoff_valid_o;
	logic turnoff_busy_o, turnoff_l3_done_o;
	logic [7:0] rx_msg_code_i;
	logic [15:0] rx_msg_rid_i, msg_data_o;
	logic [2:0] link_state_i, link_state_o;
	wire [11:0] flg;
	int mismatches = 0;
	int check_count = 0;
	int cyc = 0;
	always #10 core_clk_i = ~core_clk_i;
	rpmd_partner u_lp (.core_clk_i(core_clk_i), .tx_valid_i(tx_turnoff_valid_o), .slow_i(slow),
		.tx_ready_o(tx_turnoff_ready_i), .msg_valid_o(rx_msg_valid_i), .msg_code_o(rx_msg_code_i),
		.msg_rid_o(rx_msg_rid_i), .link_state_o(link_state_i));
	rpmd_top DUT (.core_clk_i(core_clk_i), .rst_i(rst_i), .rx_msg_valid_i(rx_msg_valid_i),
		.rx_msg_code_i(rx_msg_code_i), .rx_msg_rid_i(rx_msg_rid_i), .link_state_i(link_state_i),
		.turnoff_request_n_i(turnoff_request_n_i), .tx_turnoff_valid_o(tx_turnoff_valid_o),
		.tx_turnoff_ready_i(tx_turnoff_ready_i), .turnoff_busy_o(turnoff_busy_o),
		.turnoff_l3_done_o(turnoff_l3_done_o), .msg_strobe_o(msg_strobe_o),
		.msg_data_o(msg_data_o), .link_state_o(link_state_o),
		.rx_err_cor_flag_o(flg[0]), .rx_err_nonfatal_flag_o(flg[1]),
		.rx_err_fatal_flag_o(flg[2]), .rx_turnoff_ack_flag_o(flg[3]),
		.rx_assert_inta_flag_o(flg[4]), .rx_assert_intb_flag_o(flg[5]),
		.rx_assert_intc_flag_o(flg[6]), .rx_assert_intd_flag_o(flg[7]),
		.rx_deassert_inta_flag_o(flg[8]), .rx_deassert_intb_flag_o(flg[9]),
		.rx_deassert_intc_flag_o(flg[10]), .rx_deassert_intd_flag_o(flg[11]));
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		check_count++;
		if (got !== exp) begin
			mismatches++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic complete_run();
		$display("checks=%0d mismatches=%0d", check_count, mismatches);
		if (mismatches == 0 && check_count > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	always @(posedge core_clk_i) begin
		cyc++;
		if (cyc == 2000) begin
			mismatches++;
			complete_run();
		end
	end
	task automatic t_reset();
		chk({msg_strobe_o, tx_turnoff_valid_o, turnoff_busy_o, turnoff_l3_done_o, flg}, 16'h0000);
		chk(msg_data_o | {13'h0000, link_state_o}, 16'h0000);
		$display("reset test done");
	endtask
	task automatic t_codes();
		logic [7:0] c;
		for (int i = 0; i < 13; i++) begin
			c = (i == 12) ? 8'h7F : (i == 11) ? rpmd_pkg::CODE_DEASSERT_INTD
				: rpmd_pkg::FLG_CODES[8*i +: 8];
			u_lp.send(c, 16'h1000 + 16'(i));
			chk({15'h0000, msg_strobe_o}, 16'h0001);
			chk(msg_data_o, 16'h1000 + 16'(i));
			chk({4'h0, flg}, (i < 12) ? 16'h0001 << i : 16'h0000);
			@(posedge core_clk_i);
			#1;
			chk({3'h0, msg_strobe_o, flg}, 16'h0000);
		end
		$display("code test done");
	endtask
	task automatic t_turnoff();
		int n;
		turnoff_request_n_i = 1'b0;
		for (n = 0; n < 4 && tx_turnoff_valid_o !== 1'b1; n++) begin @(posedge core_clk_i); #1; end
		chk({14'h0000, tx_turnoff_valid_o, turnoff_busy_o}, 16'h0003);
		for (n = 0; n < 30 && msg_strobe_o !== 1'b1; n++) begin @(posedge core_clk_i); #1; end
		chk({14'h0000, flg[3], tx_turnoff_valid_o}, 16'h0002);
		for (n = 0; n < 9 && turnoff_l3_done_o !== 1'b1; n++) begin @(posedge core_clk_i); #1; end
		chk({12'h000, turnoff_l3_done_o, link_state_o}, 16'h000D);
		turnoff_request_n_i = 1'b1;
		repeat (3) @(posedge core_clk_i);
		#1;
		chk({14'h0000, turnoff_l3_done_o, turnoff_busy_o}, 16'h0000);
		$display("turn-off test done");
	endtask
	initial begin
		repeat (3) @(posedge core_clk_i);
		#1 rst_i = 1'b0;
		t_reset();
		t_codes();
		t_turnoff();
		complete_run();
	end
endmodule // testbench
